//--- src/gpio_port_pkg.sv
package gpio_port_pkg;

  // Port geometry
  localparam int NUM_PINS = 8;
  localparam int DIR_W    = 2;
  localparam int SENSE_W  = 3;
  localparam int STR_W    = 3;
  localparam int TYPE_W   = 3;

  // Register byte offsets
  localparam logic [7:0] ADDR_DATA       = 8'h00;
  localparam logic [7:0] ADDR_DIR        = 8'h04;
  localparam logic [7:0] ADDR_SENSE      = 8'h08;
  localparam logic [7:0] ADDR_PAD_STR    = 8'h0C;
  localparam logic [7:0] ADDR_PAD_TYPE   = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h14;
  localparam logic [7:0] ADDR_RAW_STAT   = 8'h18;
  localparam logic [7:0] ADDR_MASK_STAT  = 8'h1C;
  localparam logic [7:0] ADDR_ADC_TRIG   = 8'h20;
  localparam logic [7:0] ADDR_DMA_TRIG   = 8'h24;
  localparam logic [7:0] ADDR_CTRL       = 8'h28;

  // Write word layout: pin select mask and setting value
  localparam int MASK_LSB  = 8;
  localparam int VAL_LSB   = 0;
  localparam int CTRL_DISCRETE_BIT = 0;

  // Direction and control mode codes
  localparam logic [DIR_W-1:0] DIR_IN                 = 2'h0;
  localparam logic [DIR_W-1:0] DIR_OUT                = 2'h1;
  localparam logic [DIR_W-1:0] dir_peripheral_control = 2'h2;

  // Interrupt detection senses
  localparam logic [SENSE_W-1:0] SENSE_FALL = 3'h0;
  localparam logic [SENSE_W-1:0] SENSE_RISE = 3'h1;
  localparam logic [SENSE_W-1:0] SENSE_BOTH = 3'h2;
  localparam logic [SENSE_W-1:0] SENSE_LOW  = 3'h3;
  localparam logic [SENSE_W-1:0] SENSE_HIGH = 3'h4;

  // Drive strength codes
  localparam logic [STR_W-1:0] STR_2MA    = 3'h0;
  localparam logic [STR_W-1:0] STR_4MA    = 3'h1;
  localparam logic [STR_W-1:0] STR_8MA    = 3'h2;
  localparam logic [STR_W-1:0] STR_8MA_SC = 3'h3;

  // Pin type codes
  localparam logic [TYPE_W-1:0] TYPE_STD     = 3'h0;
  localparam logic [TYPE_W-1:0] TYPE_STD_WPU = 3'h1;
  localparam logic [TYPE_W-1:0] TYPE_STD_WPD = 3'h2;
  localparam logic [TYPE_W-1:0] TYPE_OD      = 3'h3;
  localparam logic [TYPE_W-1:0] TYPE_ANALOG  = 3'h4;

  // Reset values
  localparam logic [DIR_W-1:0]   DIR_RST   = DIR_IN;
  localparam logic [SENSE_W-1:0] SENSE_RST = SENSE_FALL;
  localparam logic [STR_W-1:0]   STR_RST   = STR_2MA;
  localparam logic [TYPE_W-1:0]  TYPE_RST  = TYPE_STD;
  localparam logic [7:0]         BYTE_RST  = 8'h00;
  localparam logic [31:0]        WORD_ZERO = 32'h0000_0000;

endpackage

//--- src/pin_event_detect.sv
`timescale 1ns/1ps
`default_nettype none

module pin_event_detect (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // Pin and selected sense
  input  wire logic                                pin_i,
  input  wire logic [gpio_port_pkg::SENSE_W-1:0]   sense_i,
  // Detection, one cycle per edge, held for levels
  output logic                                     hit_o
);

  logic prev;
  logic armed;
  logic next_prev;
  logic next_armed;

  always_comb begin
    next_prev  = pin_i;
    next_armed = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev  <= 1'b0;
      armed <= 1'b0;
    end else begin
      prev  <= next_prev;
      armed <= next_armed;
    end
  end

  // No edge reported before a first sample exists after reset
  always_comb begin
    case (sense_i)
      gpio_port_pkg::SENSE_FALL: hit_o = armed & prev & ~pin_i;
      gpio_port_pkg::SENSE_RISE: hit_o = armed & ~prev & pin_i;
      gpio_port_pkg::SENSE_BOTH: hit_o = armed & (prev ^ pin_i);
      gpio_port_pkg::SENSE_LOW:  hit_o = ~pin_i;
      gpio_port_pkg::SENSE_HIGH: hit_o = pin_i;
      default:                   hit_o = 1'b0;
    endcase
  end

endmodule // pin_event_detect

`default_nettype wire

//--- src/gpio_port_dir_irq_trigger.sv
// What this block does
// - Each pin selects software input, software output or peripheral control.
// - Setting writes carry an eight-bit pin mask; unselected pins keep settings.
// - Direction and mode of every pin read back in the same encoding.
// - Interrupt sense per pin: falling, rising, both edges, low or high level.
// - Selected interrupt sense of every pin reads back.
// - Optional discrete mode gives each pin its own interrupt output.
// - Each pin can be enabled or disabled as a conversion start trigger.
// - Each pin can be enabled or disabled as a DMA start trigger.
// - Trigger use never suppresses the pin's enabled interrupt.
// - Pad strength and pin type of every pin read back.
// - Eight independent pins, each an input after reset.
// - Per-pin interrupt mask; status readable raw or masked, bit n is pin n.
// - One write to either status register clears the latched interrupt of the pins set in its low byte.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_dir_irq_trigger (
  // Clock and reset
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_i,
  // Wishbone slave
  input  wire logic                                      cyc_i,
  input  wire logic                                      stb_i,
  input  wire logic                                      we_i,
  input  wire logic [7:0]                                adr_i,
  input  wire logic [3:0]                                sel_i,
  input  wire logic [31:0]                               dat_i,
  output logic      [31:0]                               dat_o,
  output logic                                           ack_o,
  output logic                                           err_o,
  // Pins
  input  wire logic [gpio_port_pkg::NUM_PINS-1:0]        pin_i,
  output logic      [gpio_port_pkg::NUM_PINS-1:0]        pin_o,
  output logic      [gpio_port_pkg::NUM_PINS-1:0]        pin_oe_o,
  // Peripheral side of pins under peripheral control
  input  wire logic [gpio_port_pkg::NUM_PINS-1:0]        periph_out_i,
  input  wire logic [gpio_port_pkg::NUM_PINS-1:0]        periph_oe_i,
  output logic      [gpio_port_pkg::NUM_PINS-1:0]        periph_in_o,
  // Pad settings
  output logic      [gpio_port_pkg::NUM_PINS*3-1:0]      pad_strength_o,
  output logic      [gpio_port_pkg::NUM_PINS*3-1:0]      pad_type_o,
  // Interrupts and triggers
  output logic                                           irq_o,
  output logic      [gpio_port_pkg::NUM_PINS-1:0]        irq_pin_o,
  output logic      [gpio_port_pkg::NUM_PINS-1:0]        adc_trig_o,
  output logic      [gpio_port_pkg::NUM_PINS-1:0]        dma_trig_o
);

  localparam int N = gpio_port_pkg::NUM_PINS;

  // Configuration state
  logic [N-1:0][gpio_port_pkg::DIR_W-1:0]   dir;
  logic [N-1:0][gpio_port_pkg::SENSE_W-1:0] sense;
  logic [N-1:0][gpio_port_pkg::STR_W-1:0]   strength;
  logic [N-1:0][gpio_port_pkg::TYPE_W-1:0]  pin_type;
  logic [N-1:0]                             out_val;
  logic [N-1:0]                             int_mask;
  logic [N-1:0]                             adc_en;
  logic [N-1:0]                             dma_en;
  logic                                     discrete;
  logic [31:0]                              rdat;
  logic                                     ack;
  logic                                     err;

  logic [N-1:0][gpio_port_pkg::DIR_W-1:0]   next_dir;
  logic [N-1:0][gpio_port_pkg::SENSE_W-1:0] next_sense;
  logic [N-1:0][gpio_port_pkg::STR_W-1:0]   next_strength;
  logic [N-1:0][gpio_port_pkg::TYPE_W-1:0]  next_pin_type;
  logic [N-1:0]                             next_out_val;
  logic [N-1:0]                             next_int_mask;
  logic [N-1:0]                             next_adc_en;
  logic [N-1:0]                             next_dma_en;
  logic                                     next_discrete;
  logic [31:0]                              next_rdat;
  logic                                     next_ack;
  logic                                     next_err;

  // Event state
  logic [N-1:0] status;
  logic [N-1:0] adc_trig;
  logic [N-1:0] dma_trig;
  logic [N-1:0] pin_drv;
  logic [N-1:0] pin_en;
  logic [N-1:0] next_status;
  logic [N-1:0] next_adc_trig;
  logic [N-1:0] next_dma_trig;
  logic [N-1:0] next_pin_drv;
  logic [N-1:0] next_pin_en;

  logic [N-1:0] hit;
  logic [N-1:0] status_clr;
  logic [N-1:0] masked_status;
  logic [N-1:0] pin_view;
  logic [31:0]  lane_mask;
  logic [31:0]  wr;
  logic [N-1:0] sel_pins;
  logic         req;
  logic         wr_req;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      pin_event_detect u_detect (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pin_i[g]),
        .sense_i (sense[g]),
        .hit_o   (hit[g])
      );
      // Read of a software output shows the driven value
      assign pin_view[g] = (dir[g] == gpio_port_pkg::DIR_OUT) ? out_val[g] : pin_i[g];
    end
  endgenerate

  // One byte lane per sel bit
  assign lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Byte lanes left out of sel read as zero, so a missing mask lane changes no per-pin setting
  assign wr       = dat_i & lane_mask;
  assign sel_pins = wr[gpio_port_pkg::MASK_LSB +: N];
  assign req      = cyc_i & stb_i & ~ack & ~err;
  assign wr_req   = req & we_i;
  assign masked_status = status & int_mask;
  assign status_clr = (wr_req && (adr_i == gpio_port_pkg::ADDR_RAW_STAT ||
                                  adr_i == gpio_port_pkg::ADDR_MASK_STAT))
                      ? wr[gpio_port_pkg::VAL_LSB +: N] : {N{1'b0}};

  always_comb begin
    next_dir      = dir;
    next_sense    = sense;
    next_strength = strength;
    next_pin_type = pin_type;
    next_out_val  = out_val;
    next_int_mask = int_mask;
    next_adc_en   = adc_en;
    next_dma_en   = dma_en;
    next_discrete = discrete;
    next_rdat     = gpio_port_pkg::WORD_ZERO;
    next_ack      = 1'b0;
    next_err      = 1'b0;
    if (req) begin
      next_ack = 1'b1;
      case (adr_i)
        gpio_port_pkg::ADDR_DATA: begin
          next_rdat[N-1:0] = pin_view;
          for (int n = 0; n < N; n++) begin
            if (we_i && sel_pins[n]) begin
              next_out_val[n] = wr[gpio_port_pkg::VAL_LSB + n];
            end
          end
        end
        gpio_port_pkg::ADDR_DIR: begin
          next_rdat[N*2-1:0] = dir;
          for (int n = 0; n < N; n++) begin
            // Unused code 3 is refused so read back always matches a legal mode
            if (we_i && sel_pins[n] && wr[1:0] != 2'h3) begin
              next_dir[n] = wr[1:0];
            end
          end
        end
        gpio_port_pkg::ADDR_SENSE: begin
          next_rdat[N*3-1:0] = sense;
          for (int n = 0; n < N; n++) begin
            if (we_i && sel_pins[n] && wr[2:0] <= gpio_port_pkg::SENSE_HIGH) begin
              next_sense[n] = wr[2:0];
            end
          end
        end
        gpio_port_pkg::ADDR_PAD_STR: begin
          next_rdat[N*3-1:0] = strength;
          for (int n = 0; n < N; n++) begin
            if (we_i && sel_pins[n] && wr[2:0] <= gpio_port_pkg::STR_8MA_SC) begin
              next_strength[n] = wr[2:0];
            end
          end
        end
        gpio_port_pkg::ADDR_PAD_TYPE: begin
          next_rdat[N*3-1:0] = pin_type;
          for (int n = 0; n < N; n++) begin
            if (we_i && sel_pins[n] && wr[2:0] <= gpio_port_pkg::TYPE_ANALOG) begin
              next_pin_type[n] = wr[2:0];
            end
          end
        end
        gpio_port_pkg::ADDR_INT_MASK: begin
          next_rdat[N-1:0] = int_mask;
          for (int n = 0; n < N; n++) begin
            if (we_i && sel_pins[n]) begin
              next_int_mask[n] = wr[gpio_port_pkg::VAL_LSB];
            end
          end
        end
        gpio_port_pkg::ADDR_RAW_STAT: begin
          next_rdat[N-1:0] = status;
        end
        gpio_port_pkg::ADDR_MASK_STAT: begin
          next_rdat[N-1:0] = masked_status;
        end
        gpio_port_pkg::ADDR_ADC_TRIG: begin
          next_rdat[N-1:0] = adc_en;
          for (int n = 0; n < N; n++) begin
            if (we_i && sel_pins[n]) begin
              next_adc_en[n] = wr[gpio_port_pkg::VAL_LSB];
            end
          end
        end
        gpio_port_pkg::ADDR_DMA_TRIG: begin
          next_rdat[N-1:0] = dma_en;
          for (int n = 0; n < N; n++) begin
            if (we_i && sel_pins[n]) begin
              next_dma_en[n] = wr[gpio_port_pkg::VAL_LSB];
            end
          end
        end
        gpio_port_pkg::ADDR_CTRL: begin
          next_rdat[gpio_port_pkg::CTRL_DISCRETE_BIT] = discrete;
          if (we_i && sel_i[0]) begin
            next_discrete = wr[gpio_port_pkg::CTRL_DISCRETE_BIT];
          end
        end
        default: begin
          next_ack = 1'b0;
          next_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir      <= {N{gpio_port_pkg::DIR_RST}};
      sense    <= {N{gpio_port_pkg::SENSE_RST}};
      strength <= {N{gpio_port_pkg::STR_RST}};
      pin_type <= {N{gpio_port_pkg::TYPE_RST}};
      out_val  <= gpio_port_pkg::BYTE_RST;
      int_mask <= gpio_port_pkg::BYTE_RST;
      adc_en   <= gpio_port_pkg::BYTE_RST;
      dma_en   <= gpio_port_pkg::BYTE_RST;
      discrete <= 1'b0;
      rdat     <= gpio_port_pkg::WORD_ZERO;
      ack      <= 1'b0;
      err      <= 1'b0;
    end else begin
      dir      <= next_dir;
      sense    <= next_sense;
      strength <= next_strength;
      pin_type <= next_pin_type;
      out_val  <= next_out_val;
      int_mask <= next_int_mask;
      adc_en   <= next_adc_en;
      dma_en   <= next_dma_en;
      discrete <= next_discrete;
      rdat     <= next_rdat;
      ack      <= next_ack;
      err      <= next_err;
    end
  end

  always_comb begin
    // A detection in the clearing cycle survives the clear
    next_status   = (status & ~status_clr) | hit;
    // Triggers ignore the interrupt mask
    next_adc_trig = hit & adc_en;
    next_dma_trig = hit & dma_en;
    for (int n = 0; n < N; n++) begin
      unique case (dir[n])
        gpio_port_pkg::dir_peripheral_control: begin
          next_pin_drv[n] = periph_out_i[n];
          next_pin_en[n]  = periph_oe_i[n];
        end
        gpio_port_pkg::DIR_OUT: begin
          next_pin_drv[n] = out_val[n];
          next_pin_en[n]  = 1'b1;
        end
        default: begin
          next_pin_drv[n] = 1'b0;
          next_pin_en[n]  = 1'b0;
        end
      endcase
      // Open drain only ever pulls low; analog pads never drive
      if (pin_type[n] == gpio_port_pkg::TYPE_OD) begin
        next_pin_en[n]  = next_pin_en[n] & ~next_pin_drv[n];
        next_pin_drv[n] = 1'b0;
      end else if (pin_type[n] == gpio_port_pkg::TYPE_ANALOG) begin
        next_pin_en[n] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status   <= gpio_port_pkg::BYTE_RST;
      adc_trig <= gpio_port_pkg::BYTE_RST;
      dma_trig <= gpio_port_pkg::BYTE_RST;
      pin_drv  <= gpio_port_pkg::BYTE_RST;
      pin_en   <= gpio_port_pkg::BYTE_RST;
    end else begin
      status   <= next_status;
      adc_trig <= next_adc_trig;
      dma_trig <= next_dma_trig;
      pin_drv  <= next_pin_drv;
      pin_en   <= next_pin_en;
    end
  end

  assign dat_o          = rdat;
  assign ack_o          = ack;
  assign err_o          = err;
  assign pin_o          = pin_drv;
  assign pin_oe_o       = pin_en;
  assign periph_in_o    = pin_i;
  assign pad_strength_o = strength;
  assign pad_type_o     = pin_type;
  assign adc_trig_o     = adc_trig;
  assign dma_trig_o     = dma_trig;
  // Combined line idles while discrete lines are in use
  assign irq_o          = ~discrete & (|masked_status);
  assign irq_pin_o      = discrete ? masked_status : {N{1'b0}};

endmodule // gpio_port_dir_irq_trigger

`default_nettype wire

//--- tb/gpio_port_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  // Pins and interrupts
  input wire logic [7:0]  pin_i,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [7:0]  periph_in_o,
  input wire logic        irq_o,
  input wire logic [7:0]  irq_pin_o,
  input wire logic [7:0]  adc_trig_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_answer_next_cycle: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("request not answered in one cycle");
  a_ack_single_pulse: assert property (ack_o |=> !ack_o && !err_o)
    else $error("ack longer than one cycle");
  a_ack_err_apart: assert property (!(ack_o && err_o))
    else $error("ack and err together");
  a_data_quiet: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_answer_has_cause: assert property (ack_o || err_o |-> $past(cyc_i) && $past(stb_i))
    else $error("answer without request");
  a_reset_inputs: assert property ($fell(rst_i) |-> pin_oe_o == 8'h00 && !irq_o)
    else $error("pins not inputs after reset");
  a_periph_sees_pin: assert property (periph_in_o == pin_i)
    else $error("peripheral input differs from pin");
  a_irq_one_style: assert property (!(irq_o && irq_pin_o != 8'h00))
    else $error("port and pin interrupts together");
  c_port_irq: cover property (irq_o);
  c_pin_irq: cover property (irq_pin_o != 8'h00);
  c_bus_err: cover property (err_o);
  c_adc_trig: cover property (adc_trig_o != 8'h00);
endmodule // gpio_port_checker
bind gpio_port_dir_irq_trigger gpio_port_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
  .err_o, .pin_i, .pin_oe_o, .periph_in_o, .irq_o, .irq_pin_o, .adc_trig_o);
`default_nettype wire

//--- tb/pin_env.sv
`timescale 1ns/1ps
`default_nettype none
module pin_env (
  // Clock
  input wire logic        clk_i,
  // Design side of the pins
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [23:0] pad_type_o,
  // Outside drivers
  input wire logic [7:0]  ext_val,
  input wire logic [7:0]  ext_oe,
  output logic     [7:0]  pin_lvl
);
  logic [7:0] flt = 8'h00;
  logic [2:0] ty;
  // Floating pins wander so a stale level never passes as driven
  always @(posedge clk_i) flt <= ~pin_lvl;
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      ty = pad_type_o[3*k+:3];
      if (pin_oe_o[k]) pin_lvl[k] = pin_o[k];
      else if (ext_oe[k]) pin_lvl[k] = ext_val[k];
      else if (ty == gpio_port_pkg::TYPE_STD_WPU) pin_lvl[k] = 1'b1;
      else if (ty == gpio_port_pkg::TYPE_STD_WPD) pin_lvl[k] = 1'b0;
      else pin_lvl[k] = flt[k];
    end
  end
endmodule // pin_env
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00, ext_val = 8'h00, ext_oe = 8'hFF, periph_out_i = 8'h00, periph_oe_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0000_0000, dat_o;
  logic ack_o, err_o, irq_o;
  logic [7:0] pin_i, pin_o, pin_oe_o, periph_in_o, irq_pin_o, adc_trig_o, dma_trig_o;
  logic [23:0] pad_strength_o, pad_type_o;
  typedef struct {bit c; bit er; logic [31:0] v; string n;} note_type;
  note_type q[$];
  int err_count = 0, n_checks = 0, cycles = 0, adc_n = 0, dma_n = 0;

  always #12.5 clk_i = ~clk_i;

  gpio_port_dir_irq_trigger uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .pin_i, .pin_o, .pin_oe_o, .periph_out_i, .periph_oe_i, .periph_in_o, .pad_strength_o,
    .pad_type_o, .irq_o, .irq_pin_o, .adc_trig_o, .dma_trig_o);
  pin_env env (.clk_i, .pin_o, .pin_oe_o, .pad_type_o, .ext_val, .ext_oe, .pin_lvl(pin_i));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (adc_trig_o[0]) adc_n++;
    if (dma_trig_o[0]) dma_n++;
    if (++cycles > 5000) begin
      err_count++;
      stop_test();
    end
  end

  // Result watcher: every answer pairs with the oldest note
  always @(posedge clk_i) if (ack_o || err_o) begin
    note_type e;
    e = q.pop_front();
    n_checks++;
    if (err_o !== e.er || (e.c && dat_o !== e.v)) begin
      err_count++;
      $display("[ERR] %s exp %h got %h err %b", e.n, e.v, dat_o, err_o);
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit c,
                    input logic [31:0] e, input string n);
    q.push_back('{c, (a > 8'h28) || (a[1:0] != 2'h0), e, n});
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    do @(posedge clk_i); while (!(ack_o || err_o));
    cyc_i <= 1'b0; stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    wb(1'b1, a, {16'h0000, m, v}, 1'b0, 32'h0000_0000, "write");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0000_0000, 1'b1, e, n);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  initial begin
    logic [31:0] e, et;
    logic [2:0] cs, ct;
    int s, c0, d0;
    bit id;
    void'($urandom(6));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 4; a <= 40; a += 4) rd(8'(a), 32'h0000_0000, "reset value");
    $display("test reset done");
    periph_out_i <= 8'($urandom);
    periph_oe_i <= 8'($urandom);
    wr(gpio_port_pkg::ADDR_DIR, 8'h09, 8'(gpio_port_pkg::DIR_OUT));
    wr(gpio_port_pkg::ADDR_DIR, 8'h02, 8'(gpio_port_pkg::dir_peripheral_control));
    wr(gpio_port_pkg::ADDR_DIR, 8'h01, 8'h03);
    rd(gpio_port_pkg::ADDR_DIR, 32'h0000_0049, "dir");
    wr(gpio_port_pkg::ADDR_DATA, 8'h09, 8'hFF);
    repeat (2) @(posedge clk_i);
    chk("oe", {4'h0, 1'b1, 1'b0, periph_oe_i[1], 1'b1}, pin_oe_o);
    chk("out", 8'h09, pin_o & 8'h09);
    e = 32'h0000_0009 | ((periph_oe_i[1] ? periph_out_i[1] : ext_val[1]) << 1);
    rd(gpio_port_pkg::ADDR_DATA, e, "data");
    wr(gpio_port_pkg::ADDR_DIR, 8'hFF, 8'(gpio_port_pkg::DIR_IN));
    repeat (2) @(posedge clk_i);
    chk("oe off", 8'h00, pin_oe_o);
    $display("test direction done");
    e = 32'h0000_0000;
    for (int k = 0; k < 8; k++) begin
      cs = 3'(k % 5);
      wr(gpio_port_pkg::ADDR_SENSE, 8'(1 << k), 8'(cs));
      e[3*k+:3] = cs;
    end
    wr(gpio_port_pkg::ADDR_SENSE, 8'hFF, 8'h05);
    rd(gpio_port_pkg::ADDR_SENSE, e, "sense");
    wr(gpio_port_pkg::ADDR_SENSE, 8'hFF, 8'(gpio_port_pkg::SENSE_RISE));
    wr(gpio_port_pkg::ADDR_ADC_TRIG, 8'h01, 8'h01);
    for (s = 0; s < 5; s++) begin
      id = (s == 0 || s == 3);
      ext_val[0] <= id;
      repeat (3) @(posedge clk_i);
      wr(gpio_port_pkg::ADDR_SENSE, 8'h01, 8'(s));
      wr(gpio_port_pkg::ADDR_INT_MASK, 8'h01, 8'(s % 2));
      if (s == 4) wr(gpio_port_pkg::ADDR_ADC_TRIG, 8'h01, 8'h00);
      wr(gpio_port_pkg::ADDR_DMA_TRIG, 8'h01, 8'(s % 2 == 0));
      wr(gpio_port_pkg::ADDR_RAW_STAT, 8'h00, 8'hFF);
      rd(gpio_port_pkg::ADDR_RAW_STAT, 32'h0000_0000, "raw quiet");
      c0 = adc_n;
      d0 = dma_n;
      ext_val[0] <= !id;
      repeat (4) @(posedge clk_i);
      rd(gpio_port_pkg::ADDR_RAW_STAT, 32'h0000_0001, "raw");
      rd(gpio_port_pkg::ADDR_MASK_STAT, 32'(s % 2), "masked");
      chk("irq", 32'(s % 2), irq_o);
      chk("adc", 32'(s < 4), s < 3 ? adc_n - c0 : 32'(adc_n != c0));
      chk("dma", 32'(s % 2 == 0), s < 3 ? dma_n - d0 : 32'(dma_n != d0));
    end
    $display("test events done");
    wr(gpio_port_pkg::ADDR_INT_MASK, 8'h01, 8'h01);
    wr(gpio_port_pkg::ADDR_CTRL, 8'h00, 8'h01);
    @(posedge clk_i);
    chk("irq pins", 8'h01, irq_pin_o);
    chk("irq port", 1'b0, irq_o);
    wr(gpio_port_pkg::ADDR_CTRL, 8'h00, 8'h00);
    @(posedge clk_i);
    chk("irq pins", 8'h00, irq_pin_o);
    chk("irq port", 1'b1, irq_o);
    wr(gpio_port_pkg::ADDR_INT_MASK, 8'h01, 8'h00);
    @(posedge clk_i);
    chk("irq masked", 1'b0, irq_o);
    ext_val[2:1] <= 2'b11;
    repeat (4) @(posedge clk_i);
    rd(gpio_port_pkg::ADDR_RAW_STAT, 32'h0000_0007, "raw pins");
    wr(gpio_port_pkg::ADDR_RAW_STAT, 8'h00, 8'h02);
    rd(gpio_port_pkg::ADDR_RAW_STAT, 32'h0000_0005, "clear");
    wr(gpio_port_pkg::ADDR_MASK_STAT, 8'h00, 8'h04);
    rd(gpio_port_pkg::ADDR_RAW_STAT, 32'h0000_0001, "clear");
    $display("test interrupts done");
    for (int k = 0; k < 8; k++) begin
      cs = 3'($urandom % 4);
      ct = 3'($urandom % 5);
      wr(gpio_port_pkg::ADDR_PAD_STR, 8'(1 << k), 8'(cs));
      wr(gpio_port_pkg::ADDR_PAD_TYPE, 8'(1 << k), 8'(ct));
      e[3*k+:3] = cs;
      et[3*k+:3] = ct;
    end
    rd(gpio_port_pkg::ADDR_PAD_STR, {8'h00, e[23:0]}, "strength");
    rd(gpio_port_pkg::ADDR_PAD_TYPE, {8'h00, et[23:0]}, "type");
    chk("strength pins", e[23:0], pad_strength_o);
    chk("type pins", et[23:0], pad_type_o);
    wr(gpio_port_pkg::ADDR_PAD_TYPE, 8'h80, 8'(gpio_port_pkg::TYPE_STD_WPU));
    ext_oe[7] <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(gpio_port_pkg::ADDR_DATA, 32'h0000_0087, "pull-up");
    wb(1'b0, 8'h2C, 32'h0000_0000, 1'b1, 32'h0000_0000, "unmapped");
    wb(1'b1, 8'h05, 32'h0000_FFFF, 1'b1, 32'h0000_0000, "unaligned");
    rd(gpio_port_pkg::ADDR_DIR, 32'h0000_0000, "dir kept");
    $display("test pads done");
    repeat (2) @(posedge clk_i);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
